// ===== core/ocmux_pkg.sv
/*
  Constants for the overcurrent threshold and multiplexed ADC
  configuration slice: register indices, byte addresses, reset
  values, field positions and answer codes.
  Assumes a 12-bit AXI4-Lite byte address with one 32-bit word
  per register.
*/
package ocmux_pkg;

  // Bus widths
  localparam int ADDR_W = 12;             // Byte address width
  localparam int DATA_W = 32;             // Bus data width
  localparam int REG_W  = 16;             // Register width

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_HIGH  = 8'h88; // Upper limit
  localparam logic [7:0] IDX_LOW   = 8'h89; // Lower limit
  localparam logic [7:0] IDX_SPARE = 8'h8A; // Scratch word
  localparam logic [7:0] IDX_CFG1  = 8'h8B; // Mux ADC config
  localparam logic [7:0] IDX_CMP   = 8'hC0; // Comparator control
  localparam logic [7:0] IDX_EVT   = 8'hC1; // Live event state
  localparam logic [7:0] IDX_ISTAT = 8'hC2; // Sticky status (RO)
  localparam logic [7:0] IDX_IEN   = 8'hC3; // Interrupt enable
  localparam logic [7:0] IDX_ICLR  = 8'hC4; // Status clear (WO)

  // Reset values
  localparam logic [15:0] HIGH_RST  = 16'h7FFF; // +FS disables
  localparam logic [15:0] LOW_RST   = 16'h8000; // -FS disables
  localparam logic [15:0] SPARE_RST = 16'h5555;
  localparam logic [15:0] CFG1_RST  = 16'h8010;
  localparam logic [15:0] CMP_RST   = 16'h0000;
  localparam logic [15:0] CFG1_WMASK = 16'h87FF; // 14:11 reserved
  localparam logic [15:0] CMP_WMASK  = 16'hDF00; // 13, 7:0 reserved

  // Field positions of the mux ADC configuration word
  localparam int CFG_EN   = 15;  // ADC enable
  localparam int CFG_VCM  = 10;  // Common-mode buffer enable
  localparam int CFG_SRCH = 7;   // Source channel LSB (3 bits)
  localparam int CFG_SNCH = 4;   // Sink channel LSB (3 bits)
  localparam int CFG_SRLV = 2;   // Source level LSB (2 bits)
  localparam int CFG_SNLV = 0;   // Sink level LSB (2 bits)

  // Field positions of the comparator control word
  localparam int CMP_EN  = 15;   // Comparator enable
  localparam int CMP_POL = 14;   // Fault pin polarity, 1 = high
  localparam int CMP_NUM = 8;    // Deglitch select LSB (5 bits)

  // Interrupt status bits
  localparam int IRQ_W     = 3;
  localparam int IRQ_UPPER = 0;  // Upper event asserted
  localparam int IRQ_LOWER = 1;  // Lower event asserted
  localparam int IRQ_CLEAR = 2;  // Mux results cleared

  // AXI answer codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ocmux_pkg

// ===== core/deglitch_counter.sv
/*
  Consecutive-conversion deglitch counter for one threshold side.
  Assumes i_sample is a one-cycle strobe per fast-filter result on
  the same clock, and i_target is 1 to 32.
*/
`timescale 1ns/1ps
`default_nettype none
module deglitch_counter (
  input  wire logic       i_clk,    // System clock
  input  wire logic       i_rst_b,  // Async reset, active low
  input  wire logic       i_enable, // Comparator enabled
  input  wire logic       i_sample, // New fast-filter result
  input  wire logic       i_over,   // Result beyond threshold
  input  wire logic [5:0] i_target, // Conversions needed to trip
  output logic            o_event   // Trip level, registered
);

  logic [5:0] cnt_q;    // Consecutive conversions beyond limit
  logic [5:0] cnt_d;
  logic       event_q;  // Trip state
  logic       event_d;
  logic [5:0] cnt_inc;  // Count including this conversion

  assign cnt_inc = cnt_q + 6'h01;

  // Restart on any fallback, so there is no hysteresis
  always_comb begin
    cnt_d   = cnt_q;
    event_d = event_q;
    if (!i_enable) begin
      cnt_d   = 6'h00;
      event_d = 1'b0;
    end else if (i_sample) begin
      if (i_over) begin
        // Saturate so a long fault does not wrap and drop out
        cnt_d   = (cnt_q >= i_target) ? cnt_q : cnt_inc; // R18
        event_d = (cnt_inc >= i_target);                 // R18
      end else begin
        cnt_d   = 6'h00;                                 // R18
        event_d = 1'b0;
      end
    end
  end

  // Count and trip state
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q   <= 6'h00;
      event_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      event_q <= event_d;
    end
  end

  assign o_event = event_q;

endmodule : deglitch_counter
`default_nettype wire

// ===== core/ocmux_regs.sv
/*
  Overcurrent threshold comparator and multiplexed ADC first
  configuration word, behind an AXI4-Lite register slave.
  Assumes the fast-filter result, its strobe, the standby level
  and the sequence step strobe all come from logic on i_clk.
*/
// What this block does
// [R1] Upper event when result exceeds upper limit
// [R2] Upper limit 7FFFh disables upper detection
// [R3] Upper limit register at 88h, reset 7FFFh
// [R4] Lower event when result below lower limit
// [R5] Lower limit 8000h disables lower detection
// [R6] Lower limit register at 89h, reset 8000h
// [R7] Limits are signed sixteen-bit, compared signed
// [R8] Scratch word at 8Ah, reset 5555h, inert
// [R9] Config word at 8Bh, reset 8010h, enable bit15
// [R10] Host edits 8Ch-9Fh only while ADC disabled; no registers here, 8Ch-9Fh answer SLVERR
// [R11] Disable or standby clears results and counter
// [R12] Bit 10 switches common-mode output buffer
// [R13] Bits 9:7 pick open-wire source channel
// [R14] Bits 6:4 pick open-wire sink channel
// [R15] Bits 3:2 set open-wire source magnitude
// [R16] Bits 1:0 set open-wire sink magnitude
// [R17] Fault active on either event, polarity chosen
// [R18] Trip after consecutive conversions, restart on fallback
// [R19] Config bits 14:11 read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module ocmux_regs (
  input  wire logic        i_clk,      // 100 MHz clock
  input  wire logic        i_rst_b,    // Async reset, active low
  input  wire logic [11:0] i_awaddr,   // Write address
  input  wire logic        i_awvalid,  // Write address valid
  output logic             o_awready,  // Write address taken
  input  wire logic [31:0] i_wdata,    // Write data
  input  wire logic [3:0]  i_wstrb,    // Write byte enables
  input  wire logic        i_wvalid,   // Write data valid
  output logic             o_wready,   // Write data taken
  output logic [1:0]       o_bresp,    // Write answer code
  output logic             o_bvalid,   // Write answer valid
  input  wire logic        i_bready,   // Write answer taken
  input  wire logic [11:0] i_araddr,   // Read address
  input  wire logic        i_arvalid,  // Read address valid
  output logic             o_arready,  // Read address taken
  output logic [31:0]      o_rdata,    // Read data
  output logic [1:0]       o_rresp,    // Read answer code
  output logic             o_rvalid,   // Read answer valid
  input  wire logic        i_rready,   // Read answer taken
  input  wire logic [15:0] i_fast_result, // Fast-filter result
  input  wire logic        i_fast_valid,  // Result strobe
  input  wire logic        i_standby,     // Standby or power-down
  input  wire logic        i_seq_step,    // Sequencer step strobe
  output logic             o_mux_adc_enable,            // ADC on
  output logic             o_common_mode_buffer_enable, // Buffer
  output logic [2:0]       o_open_wire_source_channel,  // Source
  output logic [2:0]       o_open_wire_sink_channel,    // Sink
  output logic [1:0]       o_open_wire_source_level,    // uA code
  output logic [1:0]       o_open_wire_sink_level,      // uA code
  output logic             o_upper_limit_event, // Upper trip
  output logic             o_lower_limit_event, // Lower trip
  output logic             o_fault_pin,         // Fault, polarised
  output logic             o_mux_results_clear, // Clear pulse
  output logic [1:0]       o_sequence_step_counter, // Seq count
  output logic             o_irq                // Interrupt level
);

  // Matches an aligned byte address against a register index
  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [7:0]  idx);
    reg_hit = (a == {2'b00, idx, 2'b00});
  endfunction : reg_hit

  // Merges the two low byte lanes of a write into a register
  function automatic logic [15:0] lane_merge(
      input logic [15:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  strb);
    lane_merge = {strb[1] ? new_v[15:8] : old_v[15:8],
                  strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction : lane_merge

  // Register state
  logic [15:0] high_q;    // overcurrent_high_threshold
  logic [15:0] low_q;     // overcurrent_low_threshold
  logic [15:0] spare_q;   // crc_check_scratch_word
  logic [15:0] cfg_q;     // mux_adc_config_one
  logic [15:0] cfg_d;
  logic [15:0] cmp_q;     // Comparator control
  logic [ocmux_pkg::IRQ_W-1:0] istat_q; // Sticky status
  logic [ocmux_pkg::IRQ_W-1:0] istat_d;
  logic [ocmux_pkg::IRQ_W-1:0] ien_q;   // Interrupt enable
  logic        standby_q; // Standby seen last cycle
  logic [1:0]  seq_q;     // sequence_step_counter
  logic        clear_q;   // Results clear pulse
  logic        fault_pin_q; // Polarised fault output
  logic [1:0]  ev_prev_q; // Events last cycle, for edges

  // Bus handshake state
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  // Write decode
  wire wr_fire  = i_awvalid & i_wvalid & ~bvalid_q;
  wire wr_high  = wr_fire & reg_hit(i_awaddr, ocmux_pkg::IDX_HIGH);
  wire wr_low   = wr_fire & reg_hit(i_awaddr, ocmux_pkg::IDX_LOW);
  wire wr_spare = wr_fire & reg_hit(i_awaddr, ocmux_pkg::IDX_SPARE);
  wire wr_cfg   = wr_fire & reg_hit(i_awaddr, ocmux_pkg::IDX_CFG1);
  wire wr_cmp   = wr_fire & reg_hit(i_awaddr, ocmux_pkg::IDX_CMP);
  wire wr_ien   = wr_fire & reg_hit(i_awaddr, ocmux_pkg::IDX_IEN);
  wire wr_iclr  = wr_fire & reg_hit(i_awaddr, ocmux_pkg::IDX_ICLR);
  wire wr_ro    = wr_fire & (reg_hit(i_awaddr, ocmux_pkg::IDX_EVT) |
                  reg_hit(i_awaddr, ocmux_pkg::IDX_ISTAT));
  wire wr_map   = wr_high | wr_low | wr_spare | wr_cfg | wr_cmp |
                  wr_ien | wr_iclr | wr_ro;

  // Read decode
  wire rd_fire  = i_arvalid & ~rvalid_q;
  wire rd_high  = reg_hit(i_araddr, ocmux_pkg::IDX_HIGH);
  wire rd_low   = reg_hit(i_araddr, ocmux_pkg::IDX_LOW);
  wire rd_spare = reg_hit(i_araddr, ocmux_pkg::IDX_SPARE);
  wire rd_cfg   = reg_hit(i_araddr, ocmux_pkg::IDX_CFG1);
  wire rd_cmp   = reg_hit(i_araddr, ocmux_pkg::IDX_CMP);
  wire rd_evt   = reg_hit(i_araddr, ocmux_pkg::IDX_EVT);
  wire rd_istat = reg_hit(i_araddr, ocmux_pkg::IDX_ISTAT);
  wire rd_ien   = reg_hit(i_araddr, ocmux_pkg::IDX_IEN);
  // The clear register is write-only and reads as zero
  wire rd_iclr  = reg_hit(i_araddr, ocmux_pkg::IDX_ICLR);
  wire rd_map   = rd_high | rd_low | rd_spare | rd_cfg | rd_cmp |
                  rd_evt | rd_istat | rd_ien | rd_iclr;

  // Read data select; narrow registers sit in the low half
  wire [15:0] rd_word =
      rd_high  ? high_q :
      rd_low   ? low_q :
      rd_spare ? spare_q :
      rd_cfg   ? cfg_q :
      rd_cmp   ? cmp_q :
      rd_evt   ? {10'h000, seq_q, 1'b0, o_upper_limit_event | o_lower_limit_event,
                  o_lower_limit_event, o_upper_limit_event} :
      rd_istat ? {13'h0000, istat_q} :
      rd_ien   ? {13'h0000, ien_q} : 16'h0000;

  // Comparator fields
  wire       cmp_en  = cmp_q[ocmux_pkg::CMP_EN];
  wire       cmp_pol = cmp_q[ocmux_pkg::CMP_POL];
  wire [4:0] cmp_num = cmp_q[ocmux_pkg::CMP_NUM +: 5];

  // Conversions needed to trip for a deglitch select code
  function automatic logic [5:0] trip_count(input logic [4:0] s);
    trip_count = {1'b0, s} + 6'h01;
  endfunction : trip_count

  // Signed compares; a limit at full scale masks its side
  wire signed [15:0] res_s  = i_fast_result;          // R7
  wire signed [15:0] high_s = high_q;                 // R7
  wire signed [15:0] low_s  = low_q;                  // R7
  wire high_off = (high_q == ocmux_pkg::HIGH_RST);    // R2
  wire low_off  = (low_q == ocmux_pkg::LOW_RST);      // R5
  wire over_up  = (res_s > high_s) & ~high_off;       // R1 R2
  wire over_lo  = (res_s < low_s) & ~low_off;         // R4 R5

  // One deglitch counter per side; index 0 upper, 1 lower
  wire [1:0] over_side = {over_lo, over_up};
  wire [1:0] ev_side;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_side
      deglitch_counter u_deg (
        .i_clk    (i_clk),
        .i_rst_b  (i_rst_b),
        .i_enable (cmp_en),
        .i_sample (i_fast_valid),
        .i_over   (over_side[g]),
        .i_target (trip_count(cmp_num)),
        .o_event  (ev_side[g])
      );
    end
  endgenerate

  assign o_upper_limit_event = ev_side[0];
  assign o_lower_limit_event = ev_side[1];
  wire fault_now = |ev_side;                          // R17

  // Config update; reserved bits never take a written value
  assign cfg_d = wr_cfg ?
      (lane_merge(cfg_q, i_wdata, i_wstrb) &
       ocmux_pkg::CFG1_WMASK) : cfg_q;                // R19

  // Results clear when the ADC goes off or standby begins
  wire en_fall   = cfg_q[ocmux_pkg::CFG_EN] &
                   ~cfg_d[ocmux_pkg::CFG_EN];         // R11
  wire stby_rise = i_standby & ~standby_q;            // R11
  wire seq_hold  = ~cfg_d[ocmux_pkg::CFG_EN] | i_standby;

  // Interrupt events and sticky status; a set beats a clear
  wire [ocmux_pkg::IRQ_W-1:0] irq_set =
      {en_fall | stby_rise, ev_side & ~ev_prev_q};
  wire [ocmux_pkg::IRQ_W-1:0] irq_clr =
      wr_iclr ? i_wdata[ocmux_pkg::IRQ_W-1:0] : '0;
  assign istat_d = (istat_q & ~irq_clr) | irq_set;

  // Threshold and scratch registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      high_q  <= ocmux_pkg::HIGH_RST;                 // R3
      low_q   <= ocmux_pkg::LOW_RST;                  // R6
      spare_q <= ocmux_pkg::SPARE_RST;                // R8
    end else begin
      if (wr_high) high_q <= lane_merge(high_q, i_wdata, i_wstrb);     // R3
      if (wr_low) low_q <= lane_merge(low_q, i_wdata, i_wstrb);        // R6
      // Scratch only feeds read-back; no other logic uses it
      if (wr_spare) spare_q <= lane_merge(spare_q, i_wdata, i_wstrb); // R8
    end
  end

  // Configuration and control registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q <= ocmux_pkg::CFG1_RST;                   // R9
      cmp_q <= ocmux_pkg::CMP_RST;
      ien_q <= '0;
    end else begin
      cfg_q <= cfg_d;                                 // R9
      if (wr_cmp) begin
        cmp_q <= lane_merge(cmp_q, i_wdata, i_wstrb) &
                 ocmux_pkg::CMP_WMASK;
      end
      if (wr_ien) ien_q <= i_wdata[ocmux_pkg::IRQ_W-1:0];
    end
  end

  // Sequence counter, clear pulse and standby edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      standby_q <= 1'b0;
      seq_q     <= 2'b00;
      clear_q   <= 1'b0;
    end else begin
      standby_q <= i_standby;
      clear_q   <= en_fall | stby_rise;               // R11
      if (seq_hold) seq_q <= 2'b00;                   // R11
      else if (i_seq_step) seq_q <= seq_q + 2'b01;
    end
  end

  // Fault pin and event history; pin idles inactive (high while CMP_POL is 0)
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fault_pin_q <= 1'b1;
      ev_prev_q   <= 2'b00;
      istat_q     <= '0;
    end else begin
      fault_pin_q <= cmp_pol ? fault_now : ~fault_now; // R17
      ev_prev_q   <= ev_side;
      istat_q     <= istat_d;
    end
  end

  // Bus answers; unmapped addresses get SLVERR
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q  <= ocmux_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= ocmux_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? ocmux_pkg::RESP_OKAY
                           : ocmux_pkg::RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_map ? ocmux_pkg::RESP_OKAY
                           : ocmux_pkg::RESP_SLVERR;
        rdata_q  <= {16'h0000, rd_word};
      end else if (i_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Address and data are taken together, one write at a time
  assign o_awready = wr_fire;
  assign o_wready  = wr_fire;
  assign o_arready = rd_fire;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_rvalid  = rvalid_q;
  assign o_rresp   = rresp_q;
  assign o_rdata   = rdata_q;

  // Configuration fields straight from the register
  assign o_mux_adc_enable = cfg_q[ocmux_pkg::CFG_EN];            // R9
  assign o_common_mode_buffer_enable = cfg_q[ocmux_pkg::CFG_VCM]; // R12
  assign o_open_wire_source_channel =
      cfg_q[ocmux_pkg::CFG_SRCH +: 3];                // R13
  assign o_open_wire_sink_channel =
      cfg_q[ocmux_pkg::CFG_SNCH +: 3];                // R14
  assign o_open_wire_source_level =
      cfg_q[ocmux_pkg::CFG_SRLV +: 2];                // R15
  assign o_open_wire_sink_level =
      cfg_q[ocmux_pkg::CFG_SNLV +: 2];                // R16
  assign o_fault_pin = fault_pin_q;
  assign o_mux_results_clear = clear_q;
  assign o_sequence_step_counter = seq_q;
  assign o_irq = |(istat_q & ien_q);

  // Checks
  sequence s_wr_taken;
    wr_fire;
  endsequence
  sequence s_upper_rise;
    $rose(o_upper_limit_event);
  endsequence
  a_upper_cause: assert property (@(posedge i_clk)  // R1
    disable iff (!i_rst_b)
    s_upper_rise |-> $past(i_fast_valid) && $past(over_up) &&
      $past(cmp_en))
    else $error("upper event without a qualifying result");
  a_upper_masked: assert property (@(posedge i_clk) // R2
    disable iff (!i_rst_b)
    s_upper_rise |-> $past(high_q) != ocmux_pkg::HIGH_RST)
    else $error("upper event while upper limit disabled");
  a_lower_masked: assert property (@(posedge i_clk) // R5
    disable iff (!i_rst_b)
    $rose(o_lower_limit_event) |->
      $past(low_q) != ocmux_pkg::LOW_RST && $past(res_s < low_s))
    else $error("lower event while disabled or not below");
  a_reset_values: assert property (@(posedge i_clk) // R3 R6 R8 R9
    $rose(i_rst_b) |-> high_q == ocmux_pkg::HIGH_RST &&
      low_q == ocmux_pkg::LOW_RST && cfg_q == ocmux_pkg::CFG1_RST &&
      spare_q == ocmux_pkg::SPARE_RST)
    else $error("register reset value wrong");
  a_high_write: assert property (@(posedge i_clk) // R3
    disable iff (!i_rst_b)
    s_wr_taken ##0 wr_high && i_wstrb[1:0] == 2'b11 |=>
      high_q == $past(i_wdata[15:0]) && o_bvalid)
    else $error("upper limit write lost");
  a_cfg_reserved: assert property (@(posedge i_clk) // R19
    disable iff (!i_rst_b)
    wr_cfg |=> cfg_q[14:11] == 4'h0)
    else $error("reserved config bits took a write");
  // A standby entry right after the disable may pulse again
  a_clear_step: assert property (@(posedge i_clk) // R11
    disable iff (!i_rst_b)
    $fell(o_mux_adc_enable) |-> o_mux_results_clear &&
      seq_q == 2'b00 ##1 (!o_mux_results_clear || standby_q))
    else $error("disable did not clear results once");
  a_fault_level: assert property (@(posedge i_clk) // R17
    disable iff (!i_rst_b)
    fault_now && cmp_pol |=> o_fault_pin)
    else $error("active-high fault not driven");
  a_set_wins: assert property (@(posedge i_clk)
    disable iff (!i_rst_b)
    irq_set[ocmux_pkg::IRQ_UPPER] && irq_clr[ocmux_pkg::IRQ_UPPER]
      |=> istat_q[ocmux_pkg::IRQ_UPPER])
    else $error("status clear beat a new event");
  a_trip_restart: assert property (@(posedge i_clk) // R18
    disable iff (!i_rst_b)
    i_fast_valid && !over_up |=> !o_upper_limit_event)
    else $error("upper event held after fallback");

endmodule : ocmux_regs
`default_nettype wire

// ===== verification/ocmux_host.sv
/*
  Host model: an AXI4-Lite master that programs the register slice.
  Assumes the slave answers on its own; every wait is bounded here.
*/
`timescale 1ns/1ps
`default_nettype none
module ocmux_host (
  input  wire logic        i_clk,     // Clock
  output logic [11:0]      o_awaddr,  // Write address
  output logic             o_awvalid, // Address valid
  output logic [31:0]      o_wdata,   // Write data
  output logic [3:0]       o_wstrb,   // Byte enables
  output logic             o_wvalid,  // Data valid
  output logic             o_bready,  // Answer taken
  input  wire logic        i_awready, // Address taken
  input  wire logic        i_wready,  // Data taken
  input  wire logic        i_bvalid,  // Write answer
  input  wire logic [1:0]  i_bresp,   // Write code
  output logic [11:0]      o_araddr,  // Read address
  output logic             o_arvalid, // Read valid
  output logic             o_rready,  // Read answer taken
  input  wire logic        i_arready, // Read address taken
  input  wire logic        i_rvalid,  // Read answer
  input  wire logic [31:0] i_rdata,   // Read data
  input  wire logic [1:0]  i_rresp    // Read code
);
  // Idle bus at time zero
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    {o_awaddr, o_araddr} = 24'h000000;
    {o_wdata, o_wstrb} = 36'h0;
  end

  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [15:0] dat, input logic [3:0] s,
                    output logic [1:0] r, output logic to);
    to = 1'b1;
    r  = 2'h3;
    @(posedge i_clk);
    o_awaddr  <= {2'h0, idx, 2'h0};
    o_wdata   <= {16'h0000, dat};
    o_wstrb   <= s;
    o_awvalid <= 1'b1;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    for (int n = 0; n < 200 && to; n++) begin
      @(posedge i_clk);
      if (o_awvalid && i_awready) o_awvalid <= 1'b0;
      if (o_wvalid && i_wready) o_wvalid <= 1'b0;
      if (i_bvalid) begin
        r = i_bresp;
        to = 1'b0;
        o_bready <= 1'b0;
      end
    end
  endtask : wr

  // Read: rready held high until the answer is sampled
  task automatic rd(input logic [7:0] idx, output logic [31:0] dat,
                    output logic [1:0] r, output logic to);
    to  = 1'b1;
    r   = 2'h3;
    dat = 32'h0;
    @(posedge i_clk);
    o_araddr  <= {2'h0, idx, 2'h0};
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    for (int n = 0; n < 200 && to; n++) begin
      @(posedge i_clk);
      if (o_arvalid && i_arready) o_arvalid <= 1'b0;
      if (i_rvalid) begin
        dat = i_rdata;
        r = i_rresp;
        to = 1'b0;
        o_rready <= 1'b0;
      end
    end
  endtask : rd
endmodule : ocmux_host
`default_nettype wire

// ===== verification/overcurrent_threshold_and_mux_adc_cfg_tb.sv
/*
  Self-checking bench for the threshold and mux ADC config slice.
  Assumes the host model drives the bus; bench drives the filter side.
*/
`timescale 1ns/1ps
`default_nettype none
module overcurrent_threshold_and_mux_adc_cfg_tb;
  logic clk, rst_b, aw, awr, wv, wr_, bv, br, ar, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, r, sl, kl, seq;
  logic [15:0] res;
  logic [2:0]  sc, kc;
  logic fv, stby, step, en, vcm, up, lo, flt, clr, irq, to;
  int errors, n_checks, clears;

  ocmux_regs u_ocmux_regs (.i_clk(clk), .i_rst_b(rst_b), .i_awaddr(awa), .i_awvalid(aw),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr_),
    .o_bresp(bresp), .o_bvalid(bv), .i_bready(br), .i_araddr(ara), .i_arvalid(ar),
    .o_arready(arr), .o_rdata(rdat), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr),
    .i_fast_result(res), .i_fast_valid(fv), .i_standby(stby), .i_seq_step(step),
    .o_mux_adc_enable(en), .o_common_mode_buffer_enable(vcm),
    .o_open_wire_source_channel(sc), .o_open_wire_sink_channel(kc),
    .o_open_wire_source_level(sl), .o_open_wire_sink_level(kl),
    .o_upper_limit_event(up), .o_lower_limit_event(lo), .o_fault_pin(flt),
    .o_mux_results_clear(clr), .o_sequence_step_counter(seq), .o_irq(irq));
  ocmux_host u_ocmux_host (.i_clk(clk), .o_awaddr(awa), .o_awvalid(aw), .o_wdata(wd),
    .o_wstrb(ws), .o_wvalid(wv), .o_bready(br), .i_awready(awr), .i_wready(wr_),
    .i_bvalid(bv), .i_bresp(bresp), .o_araddr(ara), .o_arvalid(ar), .o_rready(rr),
    .i_arready(arr), .i_rvalid(rv), .i_rdata(rdat), .i_rresp(rresp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count clear pulses; a one-cycle pulse is easy to miss otherwise
  always @(posedge clk) begin
    if (clr === 1'b1) clears <= clears + 1;
  end

  task automatic results();
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A bus wait that runs out ends the run as a failure
  task automatic w(input logic [7:0] idx, input logic [15:0] v, input logic [3:0] s = 4'hF);
    u_ocmux_host.wr(idx, v, s, r, to);
    if (to) begin
      errors++;
      results();
    end
  endtask : w

  task automatic rdc(input logic [7:0] idx, input logic [15:0] exp);
    u_ocmux_host.rd(idx, d, r, to);
    if (to) begin
      errors++;
      results();
    end
    chk(d, {16'h0000, exp});
  endtask : rdc

  // One filter result, then time for event and fault to settle
  task automatic smp(input logic [15:0] v);
    @(posedge clk);
    res <= v;
    fv  <= 1'b1;
    @(posedge clk);
    fv  <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : smp

  task automatic t_reset();
    rdc(8'h88, 16'h7FFF);
    rdc(8'h89, 16'h8000);
    rdc(8'h8A, 16'h5555);
    rdc(8'h8B, 16'h8010);
    chk(32'({en, vcm, sc, kc, sl, kl}), 32'h810);
    w(8'h8A, 16'hA5C3);
    w(8'h8A, 16'h1234, 4'h1);
    rdc(8'h8A, 16'hA534);
  endtask : t_reset

  // Every channel and level code, reserved bits written as ones
  task automatic t_fields();
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, 4'hF, i[0], i[2:0], ~i[2:0], i[1:0], ~i[1:0]};
      w(8'h8B, v);
      rdc(8'h8B, v & 16'h87FF);
      chk(32'({vcm, sc, kc, sl, kl}), 32'(v[10:0]));
    end
  endtask : t_fields

  task automatic t_clear();
    int c0;
    w(8'h8B, 16'h8010);
    c0 = clears;
    @(posedge clk);
    step <= 1'b1;
    repeat (3) @(posedge clk);
    step <= 1'b0;
    #1 chk(32'(seq), 32'h3);
    w(8'h8B, 16'h0010);
    repeat (2) @(posedge clk);
    chk(32'(clears - c0), 32'h1);
    chk(32'({en, seq}), 32'h0);
    w(8'h8B, 16'h8010);
    @(posedge clk);
    step <= 1'b1;
    @(posedge clk);
    stby <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(clears - c0), 32'h2);
    chk(32'(seq), 32'h0);
    stby <= 1'b0;
  endtask : t_clear

  task automatic t_limits();
    w(8'hC0, 16'hC000);
    w(8'hC3, 16'h0001);
    w(8'h88, 16'h0064);
    rdc(8'h88, 16'h0064);
    w(8'h89, 16'hFF9C);
    rdc(8'h89, 16'hFF9C);
    smp(16'h0064);
    chk(32'(up), 32'h0);
    smp(16'h0065);
    chk(32'({up, lo, flt, irq}), 32'hB);
    w(8'hC3, 16'h0000);
    #1 chk(32'(irq), 32'h0);
    w(8'hC3, 16'h0001);
    w(8'hC4, 16'h0007);
    #1 chk(32'(irq), 32'h0);
    smp(16'hFF9C);
    chk(32'({up, lo}), 32'h0);
    smp(16'hFF9B);
    chk(32'({up, lo, flt}), 32'h3);
    w(8'hC0, 16'h8000);
    repeat (2) @(posedge clk);
    #1 chk(32'(flt), 32'h0);
    w(8'h88, 16'hFFFB);
    smp(16'h0000);
    chk(32'({up, lo}), 32'h2);
    w(8'h88, 16'h7FFF);
    w(8'h89, 16'h8000);
    smp(16'h7FFF);
    chk(32'(up), 32'h0);
    smp(16'h8000);
    chk(32'(lo), 32'h0);
    w(8'h88, 16'h0064);
    w(8'hC0, 16'hC200);
    smp(16'h0065);
    smp(16'h0065);
    smp(16'h0000);
    smp(16'h0065);
    smp(16'h0065);
    chk(32'(up), 32'h0);
    smp(16'h0065);
    chk(32'(up), 32'h1);
  endtask : t_limits

  // Unmapped place: error code and zero data
  task automatic t_unmapped();
    w(8'hF0, 16'hFFFF);
    chk(32'(r), 32'h2);
    rdc(8'hF0, 16'h0000);
    chk(32'(r), 32'h2);
  endtask : t_unmapped

  initial begin
    {rst_b, fv, stby, step} = 4'h0;
    res = 16'h0000;
    {errors, n_checks, clears} = {32'h0, 32'h0, 32'h0};
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_fields();
    t_clear();
    t_limits();
    t_unmapped();
    results();
  end
endmodule : overcurrent_threshold_and_mux_adc_cfg_tb
`default_nettype wire
